// ==== src/ocp_seq_pkg.sv ====
// Constants and carrier types for the overcurrent trip test sequencer.
// Assumes a 40 MHz core clock and a classic Wishbone register port.
package ocp_seq_pkg;

  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned NUM_SLOTS     = 12;
  localparam int unsigned SLOT_W        = 4;
  localparam int unsigned VAL_W         = 16;
  localparam int unsigned TIME_W        = 32;
  localparam int unsigned LOG_MAX       = 65536;
  localparam int unsigned LOG_CNT_W     = 17;

  // Step period minimum in ms, step period maximum and delay limit in s
  localparam int unsigned STEP_MIN_MS   = 50;
  localparam int unsigned STEP_MAX_S    = 1600;
  localparam int unsigned DELAY_MAX_S   = 160;
  localparam longint unsigned STEP_MIN_CYC =
    longint'(STEP_MIN_MS) * CLK_HZ / 1000;
  localparam longint unsigned STEP_MAX_CYC =
    longint'(STEP_MAX_S) * CLK_HZ;
  localparam longint unsigned DELAY_MAX_CYC =
    longint'(DELAY_MAX_S) * CLK_HZ;

  // Global register byte addresses
  localparam logic [7:0] A_CTRL    = 8'h00;
  localparam logic [7:0] A_STATUS  = 8'h04;
  localparam logic [7:0] A_IRQ_ST  = 8'h08;
  localparam logic [7:0] A_IRQ_EN  = 8'h0C;
  localparam logic [7:0] A_IRQ_CLR = 8'h10;
  localparam logic [7:0] A_RESULT  = 8'h14;
  localparam logic [7:0] A_LOGCNT  = 8'h18;
  localparam logic [7:0] A_SLOTSEL = 8'h1C;
  // Slot window: field of the selected slot at A_SLOT_BASE + field*4
  localparam logic [7:0] A_SLOT_BASE = 8'h40;
  localparam int unsigned SLOT_STRIDE = 8'h20;
  localparam int unsigned NUM_FIELDS  = 7;

  // Slot field indices
  localparam logic [2:0] F_START = 3'h0;
  localparam logic [2:0] F_END   = 3'h1;
  localparam logic [2:0] F_STEP  = 3'h2;
  localparam logic [2:0] F_LAST  = 3'h3;
  localparam logic [2:0] F_TRIGV = 3'h4;
  localparam logic [2:0] F_PER   = 3'h5;
  localparam logic [2:0] F_DLY   = 3'h6;

  // Control bits
  localparam int unsigned C_ENA   = 0;
  localparam int unsigned C_CCMOD = 1;
  localparam int unsigned C_LOAD  = 2;

  // Event bits
  localparam int unsigned E_TRIP  = 0;
  localparam int unsigned E_TOUT  = 1;
  localparam int unsigned E_CFG   = 2;
  localparam int unsigned E_FAIL  = 3;
  localparam int unsigned EV_W    = 4;

  typedef enum logic [5:0] {
    S_IDLE  = 6'h01,
    S_ARM   = 6'h02,
    S_SETTL = 6'h04,
    S_HOLD  = 6'h08,
    S_LAST  = 6'h10,
    S_DONE  = 6'h20
  } state_e;

  typedef enum logic [2:0] {
    R_NONE = 3'h0,
    R_TRIP = 3'h1,
    R_TOUT = 3'h2,
    R_CFG  = 3'h3,
    R_FAIL = 3'h4
  } result_e;

  typedef struct packed {
    logic [VAL_W-1:0]  start_i;
    logic [VAL_W-1:0]  end_i;
    logic [VAL_W-1:0]  step_i;
    logic [VAL_W-1:0]  last_i;
    logic [VAL_W-1:0]  trig_v;
    logic [TIME_W-1:0] period;
    logic [TIME_W-1:0] delay;
    logic              hi_range;
  } slot_s;

  typedef struct packed {
    logic [VAL_W-1:0] volt;
    logic [VAL_W-1:0] curr;
  } meas_s;

  typedef struct packed {
    logic             we;
    logic [15:0]      step_no;
    meas_s            meas;
  } log_s;

endpackage

// ==== src/ocp_trip_seq.sv ====
// Overcurrent trip test sequencer: slot store, Wishbone registers,
// stepping engine, result and bounded measurement log strobe.
// Assumes measurements are synchronous to core_clk_in and already scaled.
`timescale 1ns/100ps
module ocp_trip_seq #(
  parameter int unsigned SLOTS    = ocp_seq_pkg::NUM_SLOTS,
  parameter int unsigned LOG_LIM  = ocp_seq_pkg::LOG_MAX
) (
  // Clock and reset
  input  wire logic                            core_clk_in,
  input  wire logic                            nrst_in,
  // Wishbone slave
  input  wire logic                            wb_cyc_in,
  input  wire logic                            wb_stb_in,
  input  wire logic                            wb_we_in,
  input  wire logic [7:0]                      wb_adr_in,
  input  wire logic [3:0]                      wb_sel_in,
  input  wire logic [31:0]                     wb_dat_in,
  output logic      [31:0]                     wb_dat_out,
  output logic                                 wb_ack_out,
  // Measurements of the supply under test
  input  wire ocp_seq_pkg::meas_s              meas_in,
  // Load drive
  output logic [ocp_seq_pkg::VAL_W-1:0]        iset_out,
  output logic                                 hi_range_out,
  output logic                                 sink_on_out,
  // Log strobe
  output ocp_seq_pkg::log_s                    log_out,
  // Interrupt
  output logic                                 irq_out
);

  localparam int unsigned VW = ocp_seq_pkg::VAL_W;
  localparam int unsigned TW = ocp_seq_pkg::TIME_W;
  localparam int unsigned EW = ocp_seq_pkg::EV_W;

  // Long limits saturate at the timer width instead of wrapping
  localparam longint unsigned T_CAP = {TW{1'b1}};
  localparam logic [TW-1:0] PER_HI =
    TW'((ocp_seq_pkg::STEP_MAX_CYC > T_CAP) ?
        T_CAP : ocp_seq_pkg::STEP_MAX_CYC);
  localparam logic [TW-1:0] DLY_HI =
    TW'((ocp_seq_pkg::DELAY_MAX_CYC > T_CAP) ?
        T_CAP : ocp_seq_pkg::DELAY_MAX_CYC);

  if (SLOTS < 1 || SLOTS > 16) begin : g_bad_slots
    $error("SLOTS must be 1 to 16");
  end
  if (LOG_LIM < 1 || LOG_LIM > ocp_seq_pkg::LOG_MAX) begin : g_bad_log
    $error("LOG_LIM out of range");
  end

  typedef struct packed {
    ocp_seq_pkg::slot_s [15:0]          slots;
    logic [ocp_seq_pkg::SLOT_W-1:0]     slot_sel;
    logic [2:0]                         ctrl;
    ocp_seq_pkg::state_e                st;
    ocp_seq_pkg::result_e               result;
    logic [VW-1:0]                      res_i;
    logic [VW-1:0]                      iset;
    logic [VW-1:0]                      prev_i;
    logic                               hi_range;
    logic                               sink_on;
    logic [TW-1:0]                      tmr;
    logic [15:0]                        step_no;
    logic [ocp_seq_pkg::LOG_CNT_W-1:0]  log_cnt;
    ocp_seq_pkg::log_s                  log;
    logic [EW-1:0]                      irq_st;
    logic [EW-1:0]                      irq_en;
    logic [31:0]                        rdat;
    logic                               ack;
    logic                               irq;
  } state_s;

  state_s r_r;
  state_s r_nxt;

  // Clamp a programmed time to the documented window
  function automatic logic [TW-1:0] clamp_t(input logic [TW-1:0] v,
                                            input logic [TW-1:0] lo,
                                            input logic [TW-1:0] hi);
    if (v < lo)
      clamp_t = lo;
    else if (v > hi)
      clamp_t = hi;
    else
      clamp_t = v;
  endfunction

  function automatic logic [31:0] slot_field(input ocp_seq_pkg::slot_s s,
                                             input logic [2:0] f);
    slot_field = 32'h0;
    unique case (f)
      ocp_seq_pkg::F_START: slot_field = {s.hi_range, 15'h0, s.start_i};
      ocp_seq_pkg::F_END:   slot_field = {16'h0, s.end_i};
      ocp_seq_pkg::F_STEP:  slot_field = {16'h0, s.step_i};
      ocp_seq_pkg::F_LAST:  slot_field = {16'h0, s.last_i};
      ocp_seq_pkg::F_TRIGV: slot_field = {16'h0, s.trig_v};
      ocp_seq_pkg::F_PER:   slot_field = s.period;
      ocp_seq_pkg::F_DLY:   slot_field = s.delay;
      default:              slot_field = 32'h0;
    endcase
  endfunction

  ocp_seq_pkg::slot_s cur;
  logic [TW-1:0]      per_c;
  logic [TW-1:0]      dly_c;
  logic               v_low;
  logic               v_high;
  logic               wb_req;
  logic [7:0]         soff;
  logic [3:0]         sidx;
  logic [2:0]         sfld;
  logic               in_slot;
  logic [EW-1:0]      ev;
  logic [VW:0]        next_i;

  assign cur    = r_r.slots[r_r.slot_sel];
  assign per_c  = clamp_t(cur.period,
                    TW'(ocp_seq_pkg::STEP_MIN_CYC), PER_HI);
  // Delay kept at least one cycle under the period
  assign dly_c  = clamp_t(cur.delay, '0,
                    (per_c - 1'b1 < DLY_HI) ?
                    per_c - 1'b1 : DLY_HI);
  assign v_low  = meas_in.volt < cur.trig_v;
  assign v_high = meas_in.volt > cur.trig_v;
  assign wb_req = wb_cyc_in && wb_stb_in && !r_r.ack;
  assign soff   = wb_adr_in - ocp_seq_pkg::A_SLOT_BASE;
  // One field window edits the selected slot; 12 full windows would
  // not fit the 8-bit address space
  assign sidx   = r_r.slot_sel;
  assign sfld   = soff[4:2];
  assign in_slot = (wb_adr_in >= ocp_seq_pkg::A_SLOT_BASE) &&
                   (soff[7:5] == 3'h0) &&
                   (32'(sfld) < ocp_seq_pkg::NUM_FIELDS);
  assign next_i = {1'b0, r_r.iset} + {1'b0, cur.step_i};

  always_comb begin
    r_nxt = r_r;
    ev    = '0;
    r_nxt.ack = 1'b0;
    r_nxt.log.we = 1'b0;

    // Register access
    if (wb_req) begin
      r_nxt.ack  = 1'b1;
      r_nxt.rdat = 32'h0;
      if (in_slot) begin
        r_nxt.rdat = slot_field(r_r.slots[sidx], sfld);
        if (wb_we_in && r_r.st == ocp_seq_pkg::S_IDLE) begin
          unique case (sfld)
            ocp_seq_pkg::F_START: begin
              r_nxt.slots[sidx].start_i  = wb_dat_in[VW-1:0];
              r_nxt.slots[sidx].hi_range = wb_dat_in[31];
            end
            ocp_seq_pkg::F_END:   r_nxt.slots[sidx].end_i = wb_dat_in[VW-1:0];
            ocp_seq_pkg::F_STEP:  r_nxt.slots[sidx].step_i = wb_dat_in[VW-1:0];
            ocp_seq_pkg::F_LAST:  r_nxt.slots[sidx].last_i = wb_dat_in[VW-1:0];
            ocp_seq_pkg::F_TRIGV: r_nxt.slots[sidx].trig_v = wb_dat_in[VW-1:0];
            ocp_seq_pkg::F_PER:   r_nxt.slots[sidx].period = wb_dat_in;
            ocp_seq_pkg::F_DLY:   r_nxt.slots[sidx].delay = wb_dat_in;
            default: ;
          endcase
        end
      end else begin
        unique case (wb_adr_in)
          ocp_seq_pkg::A_CTRL: begin
            r_nxt.rdat = {29'h0, r_r.ctrl};
            if (wb_we_in && wb_sel_in[0])
              r_nxt.ctrl = wb_dat_in[2:0];
          end
          ocp_seq_pkg::A_STATUS:
            r_nxt.rdat = {26'h0, r_r.st};
          ocp_seq_pkg::A_IRQ_ST:
            r_nxt.rdat = {28'h0, r_r.irq_st};
          ocp_seq_pkg::A_IRQ_EN: begin
            r_nxt.rdat = {28'h0, r_r.irq_en};
            if (wb_we_in && wb_sel_in[0])
              r_nxt.irq_en = wb_dat_in[EW-1:0];
          end
          ocp_seq_pkg::A_IRQ_CLR:
            if (wb_we_in && wb_sel_in[0])
              r_nxt.irq_st = r_r.irq_st & ~wb_dat_in[EW-1:0];
          ocp_seq_pkg::A_RESULT:
            r_nxt.rdat = {13'h0, r_r.result, r_r.res_i};
          ocp_seq_pkg::A_LOGCNT:
            r_nxt.rdat = {15'h0, r_r.log_cnt};
          ocp_seq_pkg::A_SLOTSEL: begin
            r_nxt.rdat = {28'h0, r_r.slot_sel};
            if (wb_we_in && wb_sel_in[0] && 32'(wb_dat_in[3:0]) < SLOTS &&
                r_r.st == ocp_seq_pkg::S_IDLE)
              r_nxt.slot_sel = wb_dat_in[3:0];
          end
          default: r_nxt.rdat = 32'h0;
        endcase
      end
    end

    // Stepping engine
    unique case (r_r.st)
      ocp_seq_pkg::S_IDLE: begin
        r_nxt.sink_on = 1'b0;
        if (r_r.ctrl[ocp_seq_pkg::C_LOAD] && r_r.ctrl[ocp_seq_pkg::C_ENA] &&
            r_r.ctrl[ocp_seq_pkg::C_CCMOD]) begin
          r_nxt.st       = ocp_seq_pkg::S_ARM;
          r_nxt.result   = ocp_seq_pkg::R_NONE;
          r_nxt.hi_range = cur.hi_range;
          r_nxt.iset     = '0;
          r_nxt.log_cnt  = '0;
          r_nxt.step_no  = '0;
        end
      end
      ocp_seq_pkg::S_ARM:
        if (v_high) begin
          r_nxt.st      = ocp_seq_pkg::S_SETTL;
          r_nxt.sink_on = 1'b1;
          r_nxt.iset    = cur.start_i;
          r_nxt.prev_i  = cur.start_i;
          r_nxt.tmr     = '0;
        end
      ocp_seq_pkg::S_SETTL: begin
        r_nxt.tmr = r_r.tmr + 1'b1;
        if (r_r.tmr >= dly_c) begin
          r_nxt.st = ocp_seq_pkg::S_HOLD;
          if (r_r.log_cnt < (ocp_seq_pkg::LOG_CNT_W)'(LOG_LIM)) begin
            r_nxt.log.we      = 1'b1;
            r_nxt.log.step_no = r_r.step_no;
            r_nxt.log.meas    = meas_in;
            r_nxt.log_cnt     = r_r.log_cnt + 1'b1;
          end
          if (v_low && meas_in.curr > cur.end_i) begin
            r_nxt.result = ocp_seq_pkg::R_TOUT;
            ev[ocp_seq_pkg::E_TOUT] = 1'b1;
            r_nxt.st = ocp_seq_pkg::S_DONE;
          end else if (v_low && r_r.step_no == 16'h0 &&
                       r_r.iset == cur.start_i && cur.step_i == '0) begin
            r_nxt.result = ocp_seq_pkg::R_CFG;
            ev[ocp_seq_pkg::E_CFG] = 1'b1;
            r_nxt.st = ocp_seq_pkg::S_DONE;
          end else if (v_low) begin
            r_nxt.result = ocp_seq_pkg::R_TRIP;
            r_nxt.res_i  = r_r.prev_i;
            r_nxt.iset   = cur.last_i;
            ev[ocp_seq_pkg::E_TRIP] = 1'b1;
            r_nxt.st = ocp_seq_pkg::S_LAST;
          end
        end
      end
      ocp_seq_pkg::S_HOLD: begin
        r_nxt.tmr = r_r.tmr + 1'b1;
        if (v_low) begin
          // Collapse after a settled step counts as a trip
          r_nxt.result = ocp_seq_pkg::R_TRIP;
          r_nxt.res_i  = r_r.iset;
          r_nxt.iset   = cur.last_i;
          ev[ocp_seq_pkg::E_TRIP] = 1'b1;
          r_nxt.st = ocp_seq_pkg::S_LAST;
        end else if (r_r.tmr >= per_c - 1'b1) begin
          if (r_r.iset >= cur.end_i || next_i[VW]) begin
            r_nxt.result = ocp_seq_pkg::R_FAIL;
            r_nxt.res_i  = r_r.iset;
            ev[ocp_seq_pkg::E_FAIL] = 1'b1;
            r_nxt.st = ocp_seq_pkg::S_DONE;
            r_nxt.iset = '0;
          end else begin
            r_nxt.prev_i  = r_r.iset;
            r_nxt.iset    = (next_i[VW-1:0] > cur.end_i) ?
                            cur.end_i : next_i[VW-1:0];
            r_nxt.step_no = r_r.step_no + 1'b1;
            r_nxt.tmr     = '0;
            r_nxt.st      = ocp_seq_pkg::S_SETTL;
          end
        end
      end
      ocp_seq_pkg::S_LAST:
        r_nxt.iset = cur.last_i;
      ocp_seq_pkg::S_DONE: begin
        r_nxt.sink_on = 1'b0;
        r_nxt.iset    = '0;
      end
      default: r_nxt.st = ocp_seq_pkg::S_IDLE;
    endcase

    // Load off, loss of enable or mode aborts a running test; result and irq status are kept
    if (r_r.st != ocp_seq_pkg::S_IDLE &&
        !(r_nxt.ctrl[ocp_seq_pkg::C_LOAD] && r_nxt.ctrl[ocp_seq_pkg::C_ENA] &&
          r_nxt.ctrl[ocp_seq_pkg::C_CCMOD])) begin
      r_nxt.st      = ocp_seq_pkg::S_IDLE;
      r_nxt.sink_on = 1'b0;
      r_nxt.iset    = '0;
      r_nxt.log.we  = 1'b0;
      r_nxt.result  = r_r.result;
      ev            = '0;
    end

    // Set wins over a same-cycle clear
    r_nxt.irq_st = r_nxt.irq_st | ev;
    r_nxt.irq    = |(r_nxt.irq_st & r_nxt.irq_en);
  end

  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      r_r          <= '0;
      r_r.st       <= ocp_seq_pkg::S_IDLE;
      r_r.result   <= ocp_seq_pkg::R_NONE;
    end else begin
      r_r <= r_nxt;
    end
  end

  assign wb_dat_out   = r_r.rdat;
  assign wb_ack_out   = r_r.ack;
  assign iset_out     = r_r.iset;
  assign hi_range_out = r_r.hi_range;
  assign sink_on_out  = r_r.sink_on;
  assign log_out      = r_r.log;
  assign irq_out      = r_r.irq;

endmodule

// ==== tb/ocp_trip_seq_props.sv ====
// Port checker for the overcurrent trip test sequencer.
// Assumes it is bound to the top module and sees only its ports.
`timescale 1ns/100ps
module ocp_trip_seq_props #(
  parameter int unsigned SLOTS   = ocp_seq_pkg::NUM_SLOTS,
  parameter int unsigned LOG_LIM = ocp_seq_pkg::LOG_MAX
) (
  // Clock and reset
  input  wire logic               core_clk_in,
  input  wire logic               nrst_in,
  // Wishbone
  input  wire logic               wb_cyc_in,
  input  wire logic               wb_stb_in,
  input  wire logic               wb_we_in,
  input  wire logic [7:0]         wb_adr_in,
  input  wire logic [3:0]         wb_sel_in,
  input  wire logic [31:0]        wb_dat_in,
  input  wire logic [31:0]        wb_dat_out,
  input  wire logic               wb_ack_out,
  // Supply side
  input  wire ocp_seq_pkg::meas_s meas_in,
  input  wire logic [15:0]        iset_out,
  input  wire logic               hi_range_out,
  input  wire logic               sink_on_out,
  input  wire ocp_seq_pkg::log_s  log_out,
  input  wire logic               irq_out
);
  default clocking dclk @(posedge core_clk_in);
  endclocking
  default disable iff (!nrst_in);

  a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack held longer than one cycle");
  a_ack_follows: assert property
    (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("request not answered in one cycle");
  a_ack_cause: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
    else $error("ack without a request");
  a_reset_quiet: assert property (disable iff (1'b0) !nrst_in |=>
    !wb_ack_out && !irq_out && !sink_on_out && !log_out.we)
    else $error("outputs active after reset");
  a_log_single: assert property (log_out.we |=> !log_out.we)
    else $error("log strobe longer than one cycle");
  a_log_in_test: assert property (log_out.we |-> $past(sink_on_out))
    else $error("log entry outside a running test");
  a_start_volt: assert property ($rose(sink_on_out) |->
    ($past(meas_in.volt) != 16'h0000 || $past(meas_in.volt, 2) != 16'h0000))
    else $error("load switched on without supply voltage");
  a_irq_fall: assert property ($fell(irq_out) |-> wb_ack_out && wb_we_in)
    else $error("interrupt dropped without a register write");

  c_log: cover property (log_out.we);
  c_irq: cover property ($rose(irq_out));
  c_abort: cover property ($fell(sink_on_out));
endmodule

// ==== tb/supply_model.sv ====
// Model of the supply under test as seen through the load's measurements.
// Assumes the bench commands output enable, collapse and a current offset.
`timescale 1ns/100ps
module supply_model #(
  parameter logic [15:0] V_NOM = 16'h1000
) (
  // Clock
  input  wire logic               core_clk_in,
  // Load drive
  input  wire logic [15:0]        iset_in,
  input  wire logic               sink_on_in,
  // Bench control
  input  wire logic               out_en_in,
  input  wire logic               collapse_in,
  input  wire logic [15:0]        curr_ofs_in,
  // Measurements
  output ocp_seq_pkg::meas_s      meas_out
);
  // A tripped supply resets its output to 0 V, well under any nonzero trigger
  always_ff @(posedge core_clk_in) begin
    meas_out.volt <= (out_en_in && !collapse_in) ? V_NOM : 16'h0000;
    meas_out.curr <= sink_on_in ? iset_in + curr_ofs_in : 16'h0000;
  end
endmodule

// ==== tb/ocp_trip_seq_tb_top.sv ====
// Self-checking bench for the trip test sequencer over classic Wishbone.
// Assumes the supply model stands in for the supply under test.
`timescale 1ns/100ps
module ocp_trip_seq_tb_top;
  logic               core_clk_in;
  logic               nrst_in;
  logic               wb_cyc;
  logic               wb_stb;
  logic               wb_we;
  logic [7:0]         wb_adr;
  logic [31:0]        wb_wdat;
  logic [31:0]        wb_rdat;
  logic               wb_ack;
  ocp_seq_pkg::meas_s meas;
  ocp_seq_pkg::log_s  log_o;
  logic [15:0]        iset;
  logic               hi_range;
  logic               sink_on;
  logic               irq;
  logic               out_en;
  logic               collapse;
  logic [15:0]        curr_ofs;
  logic [31:0]        cfg [7];
  logic [31:0]        dummy;
  int                 errors;
  int                 comparisons;

  ocp_trip_seq u_dut (
    .core_clk_in(core_clk_in), .nrst_in(nrst_in), .wb_cyc_in(wb_cyc),
    .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr),
    .wb_sel_in(4'hF), .wb_dat_in(wb_wdat), .wb_dat_out(wb_rdat),
    .wb_ack_out(wb_ack), .meas_in(meas), .iset_out(iset),
    .hi_range_out(hi_range), .sink_on_out(sink_on), .log_out(log_o),
    .irq_out(irq));

  supply_model u_supply (
    .core_clk_in(core_clk_in), .iset_in(iset), .sink_on_in(sink_on),
    .out_en_in(out_en), .collapse_in(collapse), .curr_ofs_in(curr_ofs),
    .meas_out(meas));

  initial begin
    core_clk_in = 1'b0;
    forever #12.5 core_clk_in = ~core_clk_in;
  end

  task automatic end_of_test();
    if (errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Request held until ack is sampled, then released for a cycle
  task automatic xfer(input logic we, input logic [7:0] adr,
                      input logic [31:0] wd, output logic [31:0] rd);
    @(posedge core_clk_in);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= adr;
    wb_wdat <= wd;
    do @(posedge core_clk_in); while (wb_ack !== 1'b1);
    rd = wb_rdat;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
    xfer(1'b1, adr, wd, dummy);
  endtask

  task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] rd;
    xfer(1'b0, adr, 32'h0, rd);
    chk(rd, exp);
  endtask

  task automatic set_slot(input logic [3:0] slot);
    wr(ocp_seq_pkg::A_SLOTSEL, {28'h0, slot});
    for (int f = 0; f < 7; f++) begin
      wr(ocp_seq_pkg::A_SLOT_BASE + 8'(f * 4), cfg[f]);
    end
  endtask

  task automatic start_run();
    wr(ocp_seq_pkg::A_CTRL, 32'h7);
    for (int i = 0; i < 40 && sink_on !== 1'b1; i++) begin
      @(posedge core_clk_in);
    end
    collapse <= 1'b1;
    repeat (60) @(posedge core_clk_in);
  endtask

  task automatic abort_run();
    wr(ocp_seq_pkg::A_CTRL, 32'h3);
    collapse <= 1'b0;
    wr(ocp_seq_pkg::A_IRQ_CLR, 32'hF);
    rd_chk(ocp_seq_pkg::A_STATUS, 32'h01);
    chk({31'h0, sink_on}, 32'h0);
  endtask

  initial begin
    repeat (5000) @(posedge core_clk_in);
    errors++;
    end_of_test();
  end

  initial begin
    errors = 0;
    comparisons = 0;
    nrst_in = 1'b0;
    wb_cyc = 1'b0;
    wb_stb = 1'b0;
    wb_we = 1'b0;
    wb_adr = 8'h00;
    wb_wdat = 32'h0;
    out_en = 1'b0;
    collapse = 1'b0;
    curr_ofs = 16'h0000;
    repeat (20) @(posedge core_clk_in);
    nrst_in <= 1'b1;
    rd_chk(ocp_seq_pkg::A_STATUS, 32'h01);
    rd_chk(8'hFC, 32'h0);
    // Delay of 50 cycles sits well below the minimum period
    cfg = '{32'h8000_0100, 32'h400, 32'h40, 32'h20, 32'h800,
            32'h001E_8480, 32'h32};
    set_slot(4'h2);
    cfg[0] = 32'h0000_0055;
    set_slot(4'h0);
    rd_chk(8'h40, 32'h0000_0055);
    wr(ocp_seq_pkg::A_SLOTSEL, 32'h2);
    rd_chk(8'h40, 32'h8000_0100);
    wr(ocp_seq_pkg::A_IRQ_EN, 32'hF);
    wr(ocp_seq_pkg::A_CTRL, 32'h5);
    rd_chk(ocp_seq_pkg::A_STATUS, 32'h01);
    wr(ocp_seq_pkg::A_CTRL, 32'h6);
    rd_chk(ocp_seq_pkg::A_STATUS, 32'h01);
    wr(ocp_seq_pkg::A_CTRL, 32'h7);
    repeat (5) @(posedge core_clk_in);
    rd_chk(ocp_seq_pkg::A_STATUS, 32'h02);
    chk({31'h0, sink_on}, 32'h0);
    out_en <= 1'b1;
    for (int i = 0; i < 40 && sink_on !== 1'b1; i++) begin
      @(posedge core_clk_in);
    end
    chk({16'h0, iset}, 32'h0100);
    chk({31'h0, hi_range}, 32'h1);
    repeat (60) @(posedge core_clk_in);
    rd_chk(ocp_seq_pkg::A_STATUS, 32'h08);
    rd_chk(ocp_seq_pkg::A_LOGCNT, 32'h1);
    collapse <= 1'b1;
    repeat (4) @(posedge core_clk_in);
    rd_chk(ocp_seq_pkg::A_RESULT, 32'h0001_0100);
    rd_chk(ocp_seq_pkg::A_STATUS, 32'h10);
    chk({16'h0, iset}, 32'h0020);
    chk({31'h0, irq}, 32'h1);
    rd_chk(ocp_seq_pkg::A_IRQ_ST, 32'h1);
    abort_run();
    chk({31'h0, irq}, 32'h0);
    // Supply collapses while the measured current is above the end level
    curr_ofs <= 16'h0400;
    start_run();
    rd_chk(ocp_seq_pkg::A_IRQ_ST, 32'h2);
    abort_run();
    curr_ofs <= 16'h0000;
    wr(8'h48, 32'h0);
    start_run();
    rd_chk(ocp_seq_pkg::A_IRQ_ST, 32'h4);
    abort_run();
    end_of_test();
  end
endmodule

bind ocp_trip_seq ocp_trip_seq_props #(.SLOTS(SLOTS), .LOG_LIM(LOG_LIM))
  u_props (
  .core_clk_in(core_clk_in), .nrst_in(nrst_in), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
  .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
  .wb_ack_out(wb_ack_out), .meas_in(meas_in), .iset_out(iset_out),
  .hi_range_out(hi_range_out), .sink_on_out(sink_on_out),
  .log_out(log_out), .irq_out(irq_out));
